// *** design/earth_fault_stage_logic.sv ***
// Purpose: one earth fault stage with start, trip and fault records
// Assumes: magnitudes and angle arrive already measured on this clock
`timescale 1ns/10ps
module earth_fault_stage_logic import efs_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int FORCE_TICK_LIMIT = FORCE_TICKS,
  parameter bit FIRST_STAGE = 1'b1
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measurements
  input wire logic [15:0] residual_input_a,
  input wire logic [15:0] residual_input_b,
  input wire logic [15:0] summed_phase_residual,
  input wire logic [15:0] peak_input_a,
  input wire logic [15:0] peak_input_b,
  input wire logic [15:0] res_part,
  input wire logic [15:0] cap_part,
  input wire logic signed [8:0] fault_angle,
  input wire logic [7:0] residual_voltage_measured,
  input wire logic [31:0] time_stamp,
  input wire logic [1:0] setting_group,
  // characteristic pin, asynchronous
  input wire logic char_input,
  // stage outputs
  output logic stage_start,
  output logic stage_trip,
  output submode_e active_submode
);

  function automatic logic is_setting(logic [7:0] a);
    return (a <= A_USER_E) || (a == A_FORCE);
  endfunction

  function automatic logic [7:0] pct_of(logic [31:0] acc, logic [31:0] thr);
    logic [39:0] p;
    p = ({8'h00, acc} * 40'(PCT_FULL)) / {8'h00, thr};
    return (p >= 40'(PCT_FULL)) ? PCT_FULL : p[7:0];
  endfunction

  logic [31:0] div_q, div_d;
  logic tick;
  logic char_m_q, char_s_q;
  ctrl_s ctrl_q, ctrl_d;
  logic [15:0] pickup_q, pickup_d, dt_q, dt_d, intrmt_q, intrmt_d;
  logic [7:0] u0_pick_q, u0_pick_d, k_q, k_d, half_q, half_d;
  logic signed [8:0] offset_q, offset_d;
  curve_s user_q, user_d, cv;
  logic unlock_q, unlock_d, force_q, force_d;
  logic fstart_q, fstart_d, ftrip_q, ftrip_d;
  logic [31:0] fcnt_q, fcnt_d;
  logic [REC_AW-1:0] rec_sel_q, rec_sel_d, wr_ptr_q, wr_ptr_d;
  logic [3:0] count_q, count_d;
  logic setup, wr_acc, we, err_q, err_d;
  logic [31:0] prdata_q, rd_d;
  logic [15:0] val, meas, excess;
  logic signed [9:0] diff;
  logic dir_ok, u0_ok, pick;
  submode_e sub, sub_q;
  logic [31:0] thr, inc, acc_next;
  stage_e state_q, state_d;
  logic [31:0] acc_q, acc_d;
  logic [15:0] hold_q, hold_d, maxc_q, maxc_d;
  logic [7:0] maxu_q, maxu_d;
  logic [1:0] grp_q, grp_d;
  logic start_q, start_d, trip_q, trip_d, rec_we;
  fault_rec_s rec_d, rec_rd;
  status_s status;

  // tick divider, all protection timing counts these 1 ms pulses
  always_comb begin
    tick = (div_q == 32'(TICK_CYCLES - 1));
    div_d = tick ? 32'h0000_0000 : div_q + 32'h0000_0001;
  end
  always_ff @(posedge clock) begin
    if (!rst_b) div_q <= 32'h0000_0000;
    else div_q <= div_d;
  end

  // pin synchroniser, second stage is the only reader of the first
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      char_m_q <= 1'b0;
      char_s_q <= 1'b0;
    end else begin
      char_m_q <= char_input;
      char_s_q <= char_m_q;
    end
  end

  // apb: zero wait states, read data and error latched at setup
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign we = wr_acc & ~err_q;
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_q;
  assign prdata = prdata_q;

  // settings, unlock and force
  always_comb begin
    ctrl_d = ctrl_q;
    pickup_d = pickup_q;
    u0_pick_d = u0_pick_q;
    dt_d = dt_q;
    k_d = k_q;
    offset_d = offset_q;
    half_d = half_q;
    intrmt_d = intrmt_q;
    user_d = user_q;
    unlock_d = unlock_q;
    rec_sel_d = rec_sel_q;
    force_d = force_q;
    fstart_d = fstart_q;
    ftrip_d = ftrip_q;
    fcnt_d = force_q ? fcnt_q + {31'h0, tick} : 32'h0000_0000;
    if (force_q && tick && fcnt_q == 32'(FORCE_TICK_LIMIT - 1)) begin
      force_d = 1'b0;
      fstart_d = 1'b0;
      ftrip_d = 1'b0;
    end
    if (we) begin
      case (paddr)
        A_CTRL: ctrl_d = ctrl_s'(pwdata[$bits(ctrl_s)-1:0]);
        A_PICKUP: pickup_d = pwdata[15:0];
        A_U0_PICKUP: u0_pick_d = pwdata[7:0];
        A_DT_DELAY: dt_d = pwdata[15:0];
        A_K_MULT: k_d = pwdata[7:0];
        A_OFFSET: offset_d = pwdata[8:0];
        A_HALF_SECTOR: half_d = pwdata[7:0];
        A_INTRMT: intrmt_d = pwdata[15:0];
        A_USER_A: user_d.a = pwdata[15:0];
        A_USER_B: user_d.b = pwdata[15:0];
        A_USER_C: user_d.c = pwdata[15:0];
        A_USER_D: user_d.d = pwdata[15:0];
        A_USER_E: user_d.e = pwdata[15:0];
        A_UNLOCK: unlock_d = (pwdata == UNLOCK_KEY);
        A_REC_SEL: rec_sel_d = pwdata[REC_AW-1:0];
        A_FORCE: begin
          force_d = pwdata[FORCE_FLAG_BIT];
          fcnt_d = 32'h0000_0000;
          // forced states need the flag already on
          fstart_d = force_q & pwdata[FORCE_FLAG_BIT]
                     & pwdata[FORCE_START_BIT];
          ftrip_d = force_q & pwdata[FORCE_FLAG_BIT]
                    & pwdata[FORCE_TRIP_BIT];
        end
        default: ;
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RST;
      pickup_q <= 16'hFFFF;
      u0_pick_q <= 8'h00;
      dt_q <= 16'h0000;
      k_q <= 8'h01;
      offset_q <= 9'h000;
      half_q <= HALF_SECTOR_RST;
      intrmt_q <= 16'h0000;
      user_q <= '0;
      unlock_q <= 1'b0;
      rec_sel_q <= '0;
      force_q <= 1'b0;
      fstart_q <= 1'b0;
      ftrip_q <= 1'b0;
      fcnt_q <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      pickup_q <= pickup_d;
      u0_pick_q <= u0_pick_d;
      dt_q <= dt_d;
      k_q <= k_d;
      offset_q <= offset_d;
      half_q <= half_d;
      intrmt_q <= intrmt_d;
      user_q <= user_d;
      unlock_q <= unlock_d;
      rec_sel_q <= rec_sel_d;
      force_q <= force_d;
      fstart_q <= fstart_d;
      ftrip_q <= ftrip_d;
      fcnt_q <= fcnt_d;
    end
  end

  // measurement selection and directional decision
  always_comb begin
    // source select, peak variants only on the first stage
    case (ctrl_q.input_sel)
      IN_B: val = residual_input_b;
      IN_CALC: val = summed_phase_residual;
      IN_A_PEAK: val = FIRST_STAGE ? peak_input_a : residual_input_a;
      IN_B_PEAK: val = FIRST_STAGE ? peak_input_b : residual_input_b;
      default: val = residual_input_a;
    endcase
    diff = 10'(fault_angle) - 10'(offset_q);
    if (diff >= ANG_HALF) diff = diff - ANG_TURN;
    else if (diff < -ANG_HALF) diff = diff + ANG_TURN;
    if (diff < 0) diff = -diff;
    u0_ok = residual_voltage_measured >= u0_pick_q;
    sub = SUB_NONE;
    meas = val;
    dir_ok = 1'b1;
    case (ctrl_q.mode)
      MODE_RESISTIVE_CAPACITIVE_MODE: begin
        if (ctrl_q.characteristic_select == CH_CAP ||
            (ctrl_q.characteristic_select == CH_DYN && char_s_q))
          sub = SUB_CAP;
        else
          sub = SUB_RES;
        meas = (sub == SUB_CAP) ? cap_part : res_part;
        dir_ok = u0_ok;
      end
      MODE_SECTOR: dir_ok = u0_ok && (diff <= 10'(half_q));
      default: ;
    endcase
    pick = (meas > pickup_q) && dir_ok;
    excess = meas - pickup_q;
  end

  // operate delay: threshold and per-tick advance of the counter
  always_comb begin
    cv = curve_consts(ctrl_q.curve, user_q);
    if (ctrl_q.curve == CV_FIXED) begin
      thr = {16'h0000, dt_q};
      inc = 32'h0000_0001;
    end else begin
      // five constants shape the inverse delay
      thr = 32'(k_q * cv.a) + {16'h0000, cv.b};
      inc = 32'h0000_0001 + ((32'(excess) * 32'(cv.c)) >> cv.d[3:0])
            + {16'h0000, cv.e};
    end
    if (thr == 32'h0000_0000) thr = 32'h0000_0001;
    acc_next = acc_q + inc;
  end

  // stage sequence, moves only on the protection tick
  always_comb begin
    state_d = state_q;
    acc_d = acc_q;
    hold_d = hold_q;
    maxc_d = (pick && meas > maxc_q) ? meas : maxc_q;
    maxu_d = (pick && residual_voltage_measured > maxu_q) ?
             residual_voltage_measured : maxu_q;
    grp_d = grp_q;
    rec_we = 1'b0;
    if (tick) begin
      case (state_q)
        ST_IDLE: if (pick) begin
          state_d = ST_RUN;
          acc_d = inc;
          maxc_d = meas;
          maxu_d = residual_voltage_measured;
          // group latched as the fault begins
          grp_d = setting_group;
        end
        ST_RUN: if (pick) begin
          acc_d = acc_next;
          if (acc_next >= thr) state_d = ST_TRIP;
        end else begin
          rec_we = 1'b1;
          // hold the count for the intermittent time
          if (intrmt_q != 16'h0000) begin
            state_d = ST_HOLD;
            hold_d = intrmt_q;
          end else begin
            state_d = ST_IDLE;
            acc_d = 32'h0000_0000;
          end
        end
        ST_HOLD: if (pick) begin
          // new start resumes the kept count
          acc_d = acc_next;
          state_d = (acc_next >= thr) ? ST_TRIP : ST_RUN;
          maxc_d = meas;
          maxu_d = residual_voltage_measured;
          grp_d = setting_group;
        end else if (hold_q <= 16'h0001) begin
          state_d = ST_IDLE;
          acc_d = 32'h0000_0000;
        end else begin
          hold_d = hold_q - 16'h0001;
        end
        ST_TRIP: if (!pick) begin
          rec_we = 1'b1;
          state_d = ST_IDLE;
          acc_d = 32'h0000_0000;
        end
        default: state_d = ST_IDLE;
      endcase
    end
    start_d = (state_d == ST_RUN) || (state_d == ST_TRIP) || fstart_d;
    trip_d = (state_d == ST_TRIP) || ftrip_d;
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      acc_q <= 32'h0000_0000;
      hold_q <= 16'h0000;
      maxc_q <= 16'h0000;
      maxu_q <= 8'h00;
      grp_q <= 2'h0;
      start_q <= 1'b0;
      trip_q <= 1'b0;
      sub_q <= SUB_NONE;
    end else begin
      state_q <= state_d;
      acc_q <= acc_d;
      hold_q <= hold_d;
      maxc_q <= maxc_d;
      maxu_q <= maxu_d;
      grp_q <= grp_d;
      start_q <= start_d;
      trip_q <= trip_d;
      sub_q <= sub;
    end
  end
  assign stage_start = start_q;
  assign stage_trip = trip_q;
  assign active_submode = sub_q;

  // record contents; trip exit always reads as full delay
  always_comb begin
    rec_d.stamp = time_stamp;
    rec_d.max_cur = maxc_q;
    rec_d.elapsed_delay_pct = (state_q == ST_TRIP) ? PCT_FULL :
                              pct_of(acc_q, thr);
    rec_d.max_u0 = maxu_q;
    rec_d.setting_group = grp_q;
    // ring pointer overwrites the oldest slot
    wr_ptr_d = rec_we ? wr_ptr_q + 1'b1 : wr_ptr_q;
    count_d = (rec_we && count_q != REC_FULL) ? count_q + 4'h1 : count_q;
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wr_ptr_q <= '0;
      count_q <= 4'h0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      count_q <= count_d;
    end
  end

  // eight-slot record store, selection 0 is the newest
  efs_rec_mem u_rec (
    .clock(clock),
    .we(rec_we),
    .waddr(wr_ptr_q),
    .wdata(rec_d),
    .raddr(wr_ptr_q - rec_sel_q - 1'b1),
    .rdata_q(rec_rd)
  );

  // register read mux and error decision, sampled in the setup cycle
  always_comb begin
    status = '{count_q, grp_q, sub_q, trip_q, start_q};
    rd_d = 32'h0000_0000;
    err_d = 1'b0;
    case (paddr)
      A_CTRL: rd_d = 32'(ctrl_q);
      A_PICKUP: rd_d = 32'(pickup_q);
      A_U0_PICKUP: rd_d = 32'(u0_pick_q);
      A_DT_DELAY: rd_d = 32'(dt_q);
      A_K_MULT: rd_d = 32'(k_q);
      A_OFFSET: rd_d = 32'(unsigned'(offset_q));
      A_HALF_SECTOR: rd_d = 32'(half_q);
      A_INTRMT: rd_d = 32'(intrmt_q);
      A_USER_A: rd_d = 32'(user_q.a);
      A_USER_B: rd_d = 32'(user_q.b);
      A_USER_C: rd_d = 32'(user_q.c);
      A_USER_D: rd_d = 32'(user_q.d);
      A_USER_E: rd_d = 32'(user_q.e);
      A_UNLOCK: rd_d = 32'(unlock_q);
      A_FORCE: rd_d = 32'({ftrip_q, fstart_q, force_q});
      A_STATUS: rd_d = 32'(status);
      A_VALUE: rd_d = 32'(meas);
      A_REC_SEL: rd_d = 32'(rec_sel_q);
      A_REC_TIME: rd_d = rec_rd.stamp;
      A_REC_VAL: rd_d = {rec_rd.max_u0, rec_rd.elapsed_delay_pct,
                         rec_rd.max_cur};
      A_REC_INFO: rd_d = 32'(rec_rd.setting_group);
      default: err_d = 1'b1;
    endcase
    if (pwrite && is_setting(paddr) && !unlock_q) err_d = 1'b1;
    if (pwrite && paddr >= A_STATUS && paddr != A_REC_SEL) err_d = 1'b1;
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= rd_d;
      err_q <= err_d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  start_on_pick_a: assert property (
    (tick && pick && state_q == ST_IDLE) |=> ##1 stage_start)
    else $error("start missing after pick-up");
  trip_on_delay_a: assert property (
    (tick && pick && state_q == ST_RUN && acc_next >= thr)
    |=> state_q == ST_TRIP ##1 stage_trip)
    else $error("trip missing at delay end");
  no_early_trip_a: assert property (
    $rose(state_q == ST_TRIP) |-> $past(acc_next) >= $past(thr))
    else $error("trip before delay elapsed");
  keep_count_a: assert property (
    (tick && pick && state_q == ST_HOLD) |=> acc_q > $past(acc_q))
    else $error("count lost within intermittent time");
  ring_ptr_a: assert property (
    rec_we |=> wr_ptr_q == $past(wr_ptr_q) + 1'b1)
    else $error("record pointer did not advance");
  full_pct_a: assert property (
    (rec_we && state_q == ST_TRIP) |-> rec_d.elapsed_delay_pct == PCT_FULL)
    else $error("tripped record not at full delay");
  submode_none_a: assert property (
    ##1 (ctrl_q.mode != MODE_RESISTIVE_CAPACITIVE_MODE) |=> active_submode == SUB_NONE)
    else $error("submode shown outside resistive mode");
  locked_ctrl_a: assert property (
    (wr_acc && paddr == A_CTRL && !unlock_q) |=> $stable(ctrl_q))
    else $error("control changed while locked");
  force_gate_a: assert property (
    !force_q |-> !fstart_q && !ftrip_q)
    else $error("forced state without force flag");
  force_timeout_a: assert property (
    (force_q && tick && fcnt_q == 32'(FORCE_TICK_LIMIT - 1)
     && !(we && paddr == A_FORCE)) |=> !force_q)
    else $error("force flag outlived timeout");

endmodule

// *** design/efs_pkg.sv ***
// Purpose: shared constants and types of the earth fault stage
// Assumes: 20 MHz clock, a 1 ms protection tick made from it
// Notes: angles are signed degrees, currents per-unit lsb, voltage percent
package efs_pkg;

  // clock, tick and timeout figures
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_PERIOD_NS = 1_000_000;
  localparam int TICK_CYC = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1)
                            / CLK_PERIOD_NS;
  localparam int FORCE_TIMEOUT_MIN = 5;
  localparam int FORCE_TICKS = FORCE_TIMEOUT_MIN * 60
                               * (1_000_000_000 / TICK_PERIOD_NS);

  // fault record store
  localparam int REC_DEPTH = 8;
  localparam int REC_AW = 3;
  localparam logic [3:0] REC_FULL = 4'h8;
  localparam logic [7:0] PCT_FULL = 8'h64; // 100 percent means trip
  localparam logic [7:0] HALF_SECTOR_RST = 8'h58; // 88 degrees
  localparam logic signed [9:0] ANG_HALF = 10'sh0B4; // 180 degrees
  localparam logic signed [9:0] ANG_TURN = 10'sh168; // 360 degrees
  // arbitrary unlock word
  localparam logic [31:0] UNLOCK_KEY = 32'h0000_C0DE;

  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PICKUP = 8'h04;
  localparam logic [7:0] A_U0_PICKUP = 8'h08;
  localparam logic [7:0] A_DT_DELAY = 8'h0C;
  localparam logic [7:0] A_K_MULT = 8'h10;
  localparam logic [7:0] A_OFFSET = 8'h14;
  localparam logic [7:0] A_HALF_SECTOR = 8'h18;
  localparam logic [7:0] A_INTRMT = 8'h1C;
  localparam logic [7:0] A_USER_A = 8'h20;
  localparam logic [7:0] A_USER_B = 8'h24;
  localparam logic [7:0] A_USER_C = 8'h28;
  localparam logic [7:0] A_USER_D = 8'h2C;
  localparam logic [7:0] A_USER_E = 8'h30;
  localparam logic [7:0] A_UNLOCK = 8'h34;
  localparam logic [7:0] A_FORCE = 8'h38;
  localparam logic [7:0] A_STATUS = 8'h3C;
  localparam logic [7:0] A_VALUE = 8'h40;
  localparam logic [7:0] A_REC_SEL = 8'h44;
  localparam logic [7:0] A_REC_TIME = 8'h48;
  localparam logic [7:0] A_REC_VAL = 8'h4C;
  localparam logic [7:0] A_REC_INFO = 8'h50;

  // force register bits
  localparam int FORCE_FLAG_BIT = 0;
  localparam int FORCE_START_BIT = 1;
  localparam int FORCE_TRIP_BIT = 2;

  typedef enum logic [1:0] {
    MODE_RESISTIVE_CAPACITIVE_MODE = 2'h0, MODE_SECTOR = 2'h1, MODE_UNDIR = 2'h2
  } dir_mode_e;
  typedef enum logic [1:0] {
    CH_RES = 2'h0, CH_CAP = 2'h1, CH_DYN = 2'h2
  } char_sel_e;
  typedef enum logic [1:0] {
    SUB_NONE = 2'h0, SUB_RES = 2'h1, SUB_CAP = 2'h2
  } submode_e;
  typedef enum logic [2:0] {
    IN_A = 3'h0, IN_B = 3'h1, IN_CALC = 3'h2, IN_A_PEAK = 3'h3,
    IN_B_PEAK = 3'h4
  } input_sel_e;
  typedef enum logic [2:0] {
    CV_FIXED = 3'h0, CV_NI = 3'h1, CV_VI = 3'h2, CV_EI = 3'h3,
    CV_LTI = 3'h4, CV_USER = 3'h5
  } curve_e;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_RUN = 4'h2, ST_HOLD = 4'h4, ST_TRIP = 4'h8
  } stage_e;

  // control register, mode in the low bits
  typedef struct packed {
    curve_e curve;
    input_sel_e input_sel;
    char_sel_e characteristic_select;
    dir_mode_e mode;
  } ctrl_s;
  localparam ctrl_s CTRL_RST = '{CV_FIXED, IN_A, CH_RES, MODE_UNDIR};

  typedef struct packed {
    logic [3:0] rec_count;
    logic [1:0] setting_group;
    submode_e active_submode;
    logic trip;
    logic start;
  } status_s;

  // a: time base, b: fixed part, c: gain, d: gain shift, e: rate offset
  typedef struct packed {
    logic [15:0] a, b, c, d, e;
  } curve_s;

  typedef struct packed {
    logic [31:0] stamp;
    logic [15:0] max_cur;
    logic [7:0] elapsed_delay_pct;
    logic [7:0] max_u0;
    logic [1:0] setting_group;
  } fault_rec_s;

  // inverse curve constants; user curve takes the five software words
  function automatic curve_s curve_consts(curve_e c, curve_s user);
    case (c)
      CV_NI: return '{16'h0064, 16'h0000, 16'h0001, 16'h0004, 16'h0000};
      CV_VI: return '{16'h0064, 16'h0000, 16'h0001, 16'h0002, 16'h0000};
      CV_EI: return '{16'h0064, 16'h0000, 16'h0001, 16'h0000, 16'h0000};
      CV_LTI: return '{16'h0190, 16'h0000, 16'h0001, 16'h0004, 16'h0000};
      default: return user;
    endcase
  endfunction

endpackage

// *** design/efs_rec_mem.sv ***
// Purpose: eight-slot store of fault records
// Assumes: one write port, one read port, same clock
// Notes: read data is registered, so it follows the address one edge later
`timescale 1ns/10ps
module efs_rec_mem import efs_pkg::*; (
  // clock
  input wire logic clock,
  // write side
  input wire logic we,
  input wire logic [REC_AW-1:0] waddr,
  input wire fault_rec_s wdata,
  // read side
  input wire logic [REC_AW-1:0] raddr,
  output fault_rec_s rdata_q
);

  fault_rec_s mem_q [REC_DEPTH];

  // storage and registered read, no reset needed for the array
  always_ff @(posedge clock) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
    rdata_q <= mem_q[raddr];
  end

endmodule

// *** verif/tb.sv ***
// Purpose: self-checking bench of the earth fault stage
// Assumes: ticks shortened to 4 clocks, force timeout to 5 ticks
// Notes: expectations come from a small behavioural model here
`timescale 1ns/10ps
module tb import efs_pkg::*;;
  localparam int TK = 4;
  logic clock, rst_b, psel, penable, pwrite, pready, pslverr, er;
  logic char_input, start, trip;
  logic [7:0] paddr, u0;
  logic [31:0] pwdata, prdata, lfsr, stamp, rd;
  logic [15:0] in_a, in_b, in_s, pk_a, pk_b, rp, cp, v;
  logic signed [8:0] ang;
  logic [1:0] grp;
  submode_e sub, e;
  ctrl_s c;
  int err_count, checked, n;
  // model of the record store, newest word first
  logic [31:0] recq[$];

  earth_fault_stage_logic #(.TICK_CYCLES(TK), .FORCE_TICK_LIMIT(5),
    .FIRST_STAGE(1'b1)) i_earth_fault_stage_logic (.clock(clock),
    .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .residual_input_a(in_a), .residual_input_b(in_b),
    .summed_phase_residual(in_s), .peak_input_a(pk_a),
    .peak_input_b(pk_b), .res_part(rp), .cap_part(cp),
    .fault_angle(ang), .residual_voltage_measured(u0),
    .time_stamp(stamp), .setting_group(grp), .char_input(char_input),
    .stage_start(start), .stage_trip(trip), .active_submode(sub));

  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // free-running clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // unselected inputs get noise so wrong selection shows up;
  // generator and stamp restart with the bench reset, one driver each
  always @(posedge clock) begin
    if (!rst_b) begin
      lfsr <= 32'h0000_380b;
      stamp <= 32'h0000_0000;
    end else begin
      lfsr <= lfsr_next(lfsr);
      stamp <= stamp + 32'h0000_0001;
    end
    in_b <= lfsr[15:0];
    in_s <= lfsr[31:16];
    pk_a <= lfsr[23:8];
    pk_b <= ~lfsr[15:0];
    rp <= lfsr[27:12];
    cp <= lfsr[19:4];
    ang <= 9'(lfsr[7:0]) - 9'd128;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic x);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge clock);
      k++;
    end
    r = prdata;
    x = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 50) begin
      err_count++;
      conclude();
    end
    @(posedge clock);
  endtask

  // bounded wait for start (0) or trip (1) to reach a level
  task automatic wait_lvl(input int which, input logic l, output int k);
    k = 0;
    while ((which == 0 ? start : trip) !== l && k < 200) begin
      @(posedge clock);
      k++;
    end
    if (k == 200) begin
      err_count++;
      $display("[FAIL] wait for level ran out");
      conclude();
    end
  endtask

  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, in_a, u0} = '0;
    {grp, char_input} = '0;
    err_count = 0;
    checked = 0;
    rst_b = 1'b0;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    apb(1'b0, A_CTRL, 0, rd, er);
    chk("ctrl reset", rd, 32'(CTRL_RST));
    apb(1'b0, A_HALF_SECTOR, 0, rd, er);
    chk("half sector", rd, 32'(HALF_SECTOR_RST));
    apb(1'b1, A_PICKUP, 32'h0000_0010, rd, er);
    chk("locked write err", 32'(er), 1);
    apb(1'b0, A_PICKUP, 0, rd, er);
    chk("pickup kept", rd, 32'h0000_ffff);
    apb(1'b0, 8'h80, 0, rd, er);
    chk("unmapped err", 32'(er), 1);
    $display("test registers done");
    apb(1'b1, A_UNLOCK, UNLOCK_KEY, rd, er);
    apb(1'b1, A_PICKUP, 32'h0000_0100, rd, er);
    apb(1'b1, A_DT_DELAY, 32'h0000_0003, rd, er);
    v = 16'h0101 + {8'h00, lfsr[7:0]};
    in_a <= v;
    u0 <= 8'h2a;
    grp <= 2'h2;
    wait_lvl(0, 1'b1, n);
    wait_lvl(1, 1'b1, n);
    chk("trip delay", n, (3 - 1) * TK);
    in_a <= 16'h0000;
    wait_lvl(0, 1'b0, n);
    recq.push_front({8'h2a, PCT_FULL, v});
    apb(1'b0, A_STATUS, 0, rd, er);
    chk("record count", 32'(rd[9:6]), 1);
    apb(1'b1, A_REC_SEL, 0, rd, er);
    apb(1'b0, A_REC_VAL, 0, rd, er);
    chk("record value", rd, recq[0]);
    apb(1'b0, A_REC_INFO, 0, rd, er);
    chk("record group", 32'(rd[1:0]), 2);
    $display("test fault done");
    apb(1'b1, A_FORCE, 32'h0000_0001, rd, er);
    apb(1'b1, A_FORCE, 32'h0000_0003, rd, er);
    chk("forced start", 32'(start), 1);
    wait_lvl(0, 1'b0, n);
    apb(1'b0, A_FORCE, 0, rd, er);
    chk("force expired", rd, 0);
    // forced states without the flag must not take
    apb(1'b1, A_FORCE, 32'h0000_0006, rd, er);
    chk("unforced start", 32'(start), 0);
    $display("test force done");
    // the last pass flips the pin under dynamic control
    for (int i = 0; i < 5; i++) begin
      c.curve = CV_FIXED;
      c.input_sel = IN_A;
      c.characteristic_select = char_sel_e'((i == 4) ? 2 : i % 3);
      c.mode = (i == 3) ? MODE_SECTOR : MODE_RESISTIVE_CAPACITIVE_MODE;
      if (i != 3) char_input <= (i == 4) ? ~char_input : lfsr[3];
      apb(1'b1, A_CTRL, 32'(c), rd, er);
      repeat (3 * TK) @(posedge clock);
      e = (i == 1 || ((i == 2 || i == 4) && char_input)) ? SUB_CAP
        : SUB_RES;
      if (i == 3) e = SUB_NONE;
      chk("submode", 32'(sub), 32'(e));
    end
    $display("test submode done");
    // intermittent faults: two short starts share one delay count;
    // records left by the random submode faults are older, not modelled
    apb(1'b1, A_CTRL, 32'(CTRL_RST), rd, er);
    repeat (2 * TK) @(posedge clock);
    apb(1'b1, A_INTRMT, 32'h0000_0008, rd, er);
    in_a <= v;
    wait_lvl(0, 1'b1, n);
    in_a <= 16'h0000;
    wait_lvl(0, 1'b0, n);
    recq.push_front({8'h2a, 8'(1 * 100 / 3), v});
    in_a <= v;
    wait_lvl(0, 1'b1, n);
    wait_lvl(1, 1'b1, n);
    chk("intermittent trip", n, (3 - 2) * TK);
    in_a <= 16'h0000;
    wait_lvl(0, 1'b0, n);
    recq.push_front({8'h2a, PCT_FULL, v});
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, A_REC_SEL, i, rd, er);
      apb(1'b0, A_REC_VAL, 0, rd, er);
      chk("record order", rd, recq[i]);
    end
    $display("test intermittent done");
    conclude();
  end
endmodule
